// ---- core/maba_alu.sv ----
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Power-down flag one after power-up, watchdog clear
// - Halt entry clears power-down flag
// - Time-out flag one after power-up, clear, halt
// - Watchdog timeout clears time-out flag
// - Register page decoded over zero to 1F
// - Secondary page decoded over zero to 15
// - Destination bit zero accumulator, one register
// - Register add with carry, three flags
// - Register add without carry, three flags
// - Immediate add with carry into accumulator
// - Immediate add without carry into accumulator
// - Register AND updates only zero flag
// - Bit clear forces bit, flags unchanged
// - Carry set on carry out after addition
// - Digit carry provided as status bit
module maba_alu (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic clock_enable_in,
   input wire maba_pkg::maba_instr_t instr_in,
   input wire logic watchdog_clear_instr_in,
   input wire logic halt_instr_in,
   input wire logic watchdog_timeout_in,
   input wire maba_pkg::maba_apb_req_t apb_in,
   output maba_pkg::maba_apb_rsp_t apb_out,
   output maba_pkg::maba_wr_t reg_wr_out,
   output logic [7:0] accumulator_out,
   output logic [7:0] status_out,
   output logic irq_out
);
   import maba_pkg::*;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [8:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic cin);
      add8 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
   endfunction

   function automatic logic digit_carry(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic cin);
      logic [4:0] low;
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      digit_carry = low[DIGIT_BIT];
   endfunction

   maba_state_t state;
   maba_state_t next_state;

   logic addr_ok;
   logic [7:0] operand_b;
   logic carry_in;
   logic [8:0] sum;
   logic [7:0] result;
   logic is_add;
   logic to_acc;
   logic exec;
   logic apb_access;
   logic [31:0] rd_word;
   logic rd_ok;

   // ---------------------------------------------------------------
   // Operand decode
   // ---------------------------------------------------------------
   always_comb begin
      addr_ok = instr_in.spage ? (instr_in.reg_addr <= SPAGE_MAX)
                               : (instr_in.reg_addr <= RPAGE_MAX);
      is_add = 1'b0;
      carry_in = 1'b0;
      operand_b = instr_in.reg_data;
      to_acc = 1'b0;
      case (instr_in.op)
         MABA_OP_ADD_REG_ACC_WITH_CARRY: begin
            is_add = 1'b1;
            carry_in = state.carry;
            to_acc = (instr_in.dest == DEST_ACC);
         end
         MABA_OP_ADD_REG_ACC: begin
            is_add = 1'b1;
            to_acc = (instr_in.dest == DEST_ACC);
         end
         MABA_OP_ADD_IMM_ACC_WITH_CARRY: begin
            is_add = 1'b1;
            carry_in = state.carry;
            operand_b = instr_in.imm;
            to_acc = 1'b1;
         end
         MABA_OP_ADD_IMM_ACC: begin
            is_add = 1'b1;
            operand_b = instr_in.imm;
            to_acc = 1'b1;
         end
         MABA_OP_AND_REG_ACC: begin
            to_acc = (instr_in.dest == DEST_ACC);
         end
         default: begin
            to_acc = 1'b0;
         end
      endcase
      sum = add8(state.acc, operand_b, carry_in);
      case (instr_in.op)
         MABA_OP_AND_REG_ACC: result = state.acc & instr_in.reg_data;
         MABA_OP_BIT_CLEAR_REG:
            result = instr_in.reg_data & ~(8'h01 << instr_in.bit_sel);
         default: result = sum[7:0];
      endcase
   end

   assign exec = clock_enable_in && state.enable && instr_in.valid &&
                 (instr_in.op != MABA_OP_NONE) && addr_ok;
   assign apb_access = apb_in.psel && apb_in.penable;

   // ---------------------------------------------------------------
   // Register read mux
   // ---------------------------------------------------------------
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      case (apb_in.paddr)
         ADDR_STATUS: rd_word = {24'h000000, status_out};
         ADDR_ACC: rd_word = {24'h000000, state.acc};
         ADDR_IRQ_STATUS: rd_word = {29'h0, state.irq_status};
         ADDR_IRQ_MASK: rd_word = {29'h0, state.irq_mask};
         ADDR_CONTROL: rd_word = {31'h0, state.enable};
         default: rd_ok = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_state.wr.valid = 1'b0;
      if (exec) begin
         if (is_add) begin
            next_state.zero = (sum[7:0] == 8'h00);
            next_state.digit = digit_carry(state.acc, operand_b,
                                           carry_in);
            next_state.carry = sum[8];
         end else if (instr_in.op == MABA_OP_AND_REG_ACC) begin
            next_state.zero = (result == 8'h00);
         end
         if (to_acc) begin
            next_state.acc = result;
         end else begin
            next_state.wr.valid = 1'b1;
            next_state.wr.addr = instr_in.reg_addr;
            next_state.wr.spage = instr_in.spage;
            next_state.wr.data = result;
         end
      end
      if (clock_enable_in) begin
         if (halt_instr_in) begin
            next_state.power_down = 1'b0;
            next_state.time_out = 1'b1;
         end
         if (watchdog_clear_instr_in) begin
            next_state.power_down = 1'b1;
            next_state.time_out = 1'b1;
         end
         if (watchdog_timeout_in) begin
            next_state.time_out = 1'b0;
         end
         // Clear only the bits already shown in the read word
         if (apb_access && !apb_in.pwrite &&
             apb_in.paddr == ADDR_IRQ_STATUS) begin
            next_state.irq_status = state.irq_status &
                                    ~state.prdata[IRQ_W-1:0];
         end
         if (exec && is_add && sum[7:0] == 8'h00) begin
            next_state.irq_status[IRQ_ZERO] = 1'b1;
         end
         if (exec && is_add && sum[8]) begin
            next_state.irq_status[IRQ_CARRY] = 1'b1;
         end
         if (watchdog_timeout_in) begin
            next_state.irq_status[IRQ_TIMEOUT] = 1'b1;
         end
         if (apb_access && apb_in.pwrite) begin
            case (apb_in.paddr)
               ADDR_ACC: next_state.acc = apb_in.pwdata[7:0];
               ADDR_IRQ_MASK: next_state.irq_mask = apb_in.pwdata[2:0];
               ADDR_CONTROL: next_state.enable = apb_in.pwdata[CTL_ENABLE];
               default: next_state.enable = next_state.enable;
            endcase
         end
         // Read word and error taken in setup, held through access
         if (apb_in.psel && !apb_in.penable) begin
            next_state.prdata = apb_in.pwrite ? 32'h0000_0000 : rd_word;
            next_state.bad_addr = !rd_ok;
         end
      end else begin
         next_state = state;
         next_state.wr.valid = state.wr.valid;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         state <= '0;
         state.acc <= ACC_RESET;
         state.power_down <= 1'b1;
         state.time_out <= 1'b1;
         state.irq_mask <= IRQ_MASK_RESET;
         state.enable <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_comb begin
      status_out = 8'h00;
      status_out[ST_C] = state.carry;
      status_out[ST_DC] = state.digit;
      status_out[ST_Z] = state.zero;
      status_out[ST_PD] = state.power_down;
      status_out[ST_TO] = state.time_out;
   end

   assign accumulator_out = state.acc;
   assign reg_wr_out = state.wr;
   assign irq_out = |(state.irq_status & state.irq_mask);
   assign apb_out.pready = 1'b1;
   assign apb_out.pslverr = apb_access && state.bad_addr;
   assign apb_out.prdata = state.prdata;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_pd_clear;
      @(posedge clock_in) disable iff (!reset_n_in)
      clock_enable_in && watchdog_clear_instr_in |=> state.power_down;
   endproperty
   a_pd_clear: assert property (p_pd_clear)
      else $error("power down flag not set by watchdog clear");

   property p_pd_halt;
      @(posedge clock_in) disable iff (!reset_n_in)
      clock_enable_in && halt_instr_in && !watchdog_clear_instr_in
      |=> !state.power_down;
   endproperty
   a_pd_halt: assert property (p_pd_halt)
      else $error("power down flag not cleared by halt");

   property p_to_set;
      @(posedge clock_in) disable iff (!reset_n_in)
      clock_enable_in && (halt_instr_in || watchdog_clear_instr_in) &&
      !watchdog_timeout_in |=> state.time_out;
   endproperty
   a_to_set: assert property (p_to_set)
      else $error("time out flag not set");

   property p_to_timeout;
      @(posedge clock_in) disable iff (!reset_n_in)
      clock_enable_in && watchdog_timeout_in |=> !status_out[ST_TO];
   endproperty
   a_to_timeout: assert property (p_to_timeout)
      else $error("time out flag not cleared by timeout");

   property p_dest_reg;
      @(posedge clock_in) disable iff (!reset_n_in)
      exec && instr_in.op == MABA_OP_ADD_REG_ACC &&
      instr_in.dest == DEST_REG
      |=> reg_wr_out.valid && accumulator_out == $past(state.acc);
   endproperty
   a_dest_reg: assert property (p_dest_reg)
      else $error("register destination not honoured");

   property p_add_carry;
      @(posedge clock_in) disable iff (!reset_n_in)
      exec && instr_in.op == MABA_OP_ADD_IMM_ACC_WITH_CARRY
      |=> {state.carry, state.acc} == ({1'b0, $past(state.acc)} +
          {1'b0, $past(instr_in.imm)} + {8'h00, $past(state.carry)});
   endproperty
   a_add_carry: assert property (p_add_carry)
      else $error("immediate add with carry wrong");

   property p_and_flags;
      @(posedge clock_in) disable iff (!reset_n_in)
      exec && instr_in.op == MABA_OP_AND_REG_ACC
      |=> state.carry == $past(state.carry) &&
          state.digit == $past(state.digit);
   endproperty
   a_and_flags: assert property (p_and_flags)
      else $error("and changed carry flags");

   property p_bit_clear;
      @(posedge clock_in) disable iff (!reset_n_in)
      exec && instr_in.op == MABA_OP_BIT_CLEAR_REG
      |=> reg_wr_out.data[$past(instr_in.bit_sel)] == 1'b0 &&
          status_out[2:0] == $past(status_out[2:0]);
   endproperty
   a_bit_clear: assert property (p_bit_clear)
      else $error("bit clear wrong");

   property p_range;
      @(posedge clock_in) disable iff (!reset_n_in)
      clock_enable_in && instr_in.valid && !instr_in.spage &&
      instr_in.reg_addr > RPAGE_MAX |=> !reg_wr_out.valid;
   endproperty
   a_range: assert property (p_range)
      else $error("out of range register accepted");

   property p_spage_range;
      @(posedge clock_in) disable iff (!reset_n_in)
      clock_enable_in && instr_in.valid && instr_in.spage &&
      instr_in.reg_addr > SPAGE_MAX |=> !reg_wr_out.valid;
   endproperty
   a_spage_range: assert property (p_spage_range)
      else $error("out of range secondary register accepted");

   property p_add_reg_carry;
      @(posedge clock_in) disable iff (!reset_n_in)
      exec && instr_in.op == MABA_OP_ADD_REG_ACC_WITH_CARRY &&
      instr_in.dest == DEST_ACC
      |=> {state.carry, state.acc} == ({1'b0, $past(state.acc)} +
          {1'b0, $past(instr_in.reg_data)} + {8'h00, $past(state.carry)});
   endproperty
   a_add_reg_carry: assert property (p_add_reg_carry)
      else $error("register add with carry wrong");

   property p_add_reg;
      @(posedge clock_in) disable iff (!reset_n_in)
      exec && instr_in.op == MABA_OP_ADD_REG_ACC &&
      instr_in.dest == DEST_REG
      |=> {state.carry, reg_wr_out.data} == ({1'b0, $past(state.acc)} +
          {1'b0, $past(instr_in.reg_data)}) &&
          state.zero == (reg_wr_out.data == 8'h00);
   endproperty
   a_add_reg: assert property (p_add_reg)
      else $error("register add wrong");

   property p_add_imm;
      @(posedge clock_in) disable iff (!reset_n_in)
      exec && instr_in.op == MABA_OP_ADD_IMM_ACC
      |=> {state.carry, state.acc} == ({1'b0, $past(state.acc)} +
          {1'b0, $past(instr_in.imm)});
   endproperty
   a_add_imm: assert property (p_add_imm)
      else $error("immediate add wrong");

   property p_digit;
      @(posedge clock_in) disable iff (!reset_n_in)
      exec && instr_in.op == MABA_OP_ADD_IMM_ACC
      |=> state.digit == (({1'b0, $past(state.acc[3:0])} +
          {1'b0, $past(instr_in.imm[3:0])}) > 5'h0F);
   endproperty
   a_digit: assert property (p_digit)
      else $error("digit carry not from bit 3");
endmodule // maba_alu
`default_nettype wire

// ---- core/maba_pkg.sv ----
package maba_pkg;
   // ---------------------------------------------------------------
   // Operation codes
   // ---------------------------------------------------------------
   localparam int OP_W = 3;
   typedef enum logic [2:0] {
      MABA_OP_NONE = 3'h0,
      MABA_OP_ADD_REG_ACC_WITH_CARRY = 3'h1,
      MABA_OP_ADD_REG_ACC = 3'h2,
      MABA_OP_ADD_IMM_ACC_WITH_CARRY = 3'h3,
      MABA_OP_ADD_IMM_ACC = 3'h4,
      MABA_OP_AND_REG_ACC = 3'h5,
      MABA_OP_BIT_CLEAR_REG = 3'h6
   } maba_op_t;

   // ---------------------------------------------------------------
   // Address ranges and widths
   // ---------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam logic [6:0] RPAGE_MAX = 7'h1F;
   localparam logic [6:0] SPAGE_MAX = 7'h15;
   localparam int DIGIT_BIT = 4;
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_REG = 1'b1;
   localparam logic [7:0] ACC_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Status register layout (flags read by software)
   // ---------------------------------------------------------------
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_PD = 3;
   localparam int ST_TO = 4;

   // ---------------------------------------------------------------
   // APB register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_ACC = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_CONTROL = 8'h10;
   localparam int IRQ_W = 3;
   localparam int IRQ_ZERO = 0;
   localparam int IRQ_CARRY = 1;
   localparam int IRQ_TIMEOUT = 2;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   localparam int CTL_ENABLE = 0;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic valid;
      maba_op_t op;
      logic [6:0] reg_addr;
      logic spage;
      logic dest;
      logic [2:0] bit_sel;
      logic [7:0] imm;
      logic [7:0] reg_data;
   } maba_instr_t;

   typedef struct packed {
      logic valid;
      logic [6:0] addr;
      logic spage;
      logic [7:0] data;
   } maba_wr_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } maba_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } maba_apb_rsp_t;

   typedef struct packed {
      logic [7:0] acc;
      logic carry;
      logic digit;
      logic zero;
      logic power_down;
      logic time_out;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      logic enable;
      maba_wr_t wr;
      logic bad_addr;
      logic [31:0] prdata;
   } maba_state_t;
endpackage

// ---- sim/maba_regfile_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Register file behind the datapath, both pages
// ---------------------------------------------------------------
module maba_regfile_model (
   input wire logic clock_in,
   input wire maba_pkg::maba_wr_t wr_in,
   input wire logic [7:0] rd_index_in,
   output logic [7:0] rd_data_out
);
   import maba_pkg::*;
   // Index is {page, address}; holes stay unknown until loaded
   logic [7:0] mem [0:255];

   assign rd_data_out = mem[rd_index_in];

   always @(posedge clock_in) begin
      if (wr_in.valid === 1'b1) begin
         mem[{wr_in.spage, wr_in.addr}] <= wr_in.data;
      end
   end
endmodule // maba_regfile_model
`default_nettype wire

// ---- sim/mcu_add_and_bitclear_alu_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcu_add_and_bitclear_alu_test;
   import maba_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   logic clock_in = 1'b0;
   logic reset_n = 1'b0;
   logic ce = 1'b1;
   logic wdc = 1'b0;
   logic hlt = 1'b0;
   logic wto = 1'b0;
   maba_instr_t ins_q = '0;
   maba_instr_t ins;
   maba_apb_req_t apb = '0;
   maba_apb_rsp_t rsp;
   maba_wr_t wr;
   logic [7:0] acc, st, rd;
   logic irq, rerr, rrdy;
   logic [31:0] rdata;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;

   always #10 clock_in = ~clock_in;

   always_comb begin
      ins = ins_q;
      ins.reg_data = rd;
   end

   maba_alu u_dut (.clock_in(clock_in), .reset_n_in(reset_n),
      .clock_enable_in(ce), .instr_in(ins), .watchdog_clear_instr_in(wdc),
      .halt_instr_in(hlt), .watchdog_timeout_in(wto), .apb_in(apb),
      .apb_out(rsp), .reg_wr_out(wr), .accumulator_out(acc),
      .status_out(st), .irq_out(irq));

   maba_regfile_model u_model (.clock_in(clock_in), .wr_in(wr),
      .rd_index_in({ins_q.spage, ins_q.reg_addr}), .rd_data_out(rd));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   task automatic apb_xfer(input logic w, input logic [7:0] a,
                           input logic [31:0] d);
      @(posedge clock_in);
      apb <= '{1'b1, 1'b0, w, a, d};
      @(posedge clock_in);
      apb.penable <= 1'b1;
      do begin
         @(posedge clock_in);
         rdata = rsp.prdata;
         rerr = rsp.pslverr;
         rrdy = rsp.pready;
      end while (rrdy !== 1'b1);
      apb <= '0;
      #1;
   endtask

   task automatic do_op(input maba_op_t op, input logic [6:0] a,
                        input logic sp, input logic d, input logic [2:0] b,
                        input logic [7:0] im);
      @(posedge clock_in);
      ins_q <= '{1'b1, op, a, sp, d, b, im, 8'h00};
      @(posedge clock_in);
      ins_q.valid <= 1'b0;
      #1;
   endtask

   // Index 0 watchdog clear, 1 halt entry, 2 watchdog timeout
   task automatic pulse(input int k);
      @(posedge clock_in);
      {wdc, hlt, wto} <= 3'h4 >> k;
      @(posedge clock_in);
      {wdc, hlt, wto} <= 3'h0;
      #1;
   endtask

   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         end_sim();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clock_in);
      reset_n <= 1'b1;
      #1;
      chk("status", 32'h18, st);
      apb_xfer(1'b1, ADDR_IRQ_MASK, 32'h7);
      apb_xfer(1'b1, ADDR_ACC, 32'h12);
      apb_xfer(1'b0, ADDR_ACC, 32'h0);
      chk("acc read", 32'h12, rdata);
      u_model.mem[8'h05] = 8'h34;
      do_op(MABA_OP_ADD_REG_ACC, 7'h05, 1'b0, DEST_REG, 3'h0, 8'h00);
      chk("wr valid", 32'h1, wr.valid);
      chk("wr data", 32'h46, wr.data);
      chk("acc", 32'h12, acc);
      chk("status", 32'h18, st);
      do_op(MABA_OP_ADD_IMM_ACC, 7'h00, 1'b0, DEST_ACC, 3'h0, 8'hEE);
      chk("acc", 32'h00, acc);
      chk("status", 32'h1F, st);
      chk("irq", 32'h1, irq);
      apb_xfer(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk("irq status", 32'h3, rdata);
      chk("irq", 32'h0, irq);
      u_model.mem[8'h1F] = 8'h34;
      do_op(MABA_OP_ADD_REG_ACC_WITH_CARRY, 7'h1F, 1'b0, DEST_ACC, 3'h0,
            8'h00);
      chk("acc", 32'h35, acc);
      chk("wr valid", 32'h0, wr.valid);
      chk("status", 32'h18, st);
      do_op(MABA_OP_ADD_IMM_ACC_WITH_CARRY, 7'h00, 1'b0, DEST_ACC, 3'h0,
            8'h0B);
      chk("acc", 32'h40, acc);
      chk("status", 32'h1A, st);
      u_model.mem[8'h95] = 8'h0F;
      do_op(MABA_OP_AND_REG_ACC, 7'h15, 1'b1, DEST_ACC, 3'h0, 8'h00);
      chk("acc", 32'h00, acc);
      chk("status", 32'h1E, st);
      u_model.mem[8'h20] = 8'h01;
      u_model.mem[8'h96] = 8'h01;
      do_op(MABA_OP_ADD_REG_ACC, 7'h20, 1'b0, DEST_REG, 3'h0, 8'h00);
      chk("wr valid", 32'h0, wr.valid);
      do_op(MABA_OP_ADD_REG_ACC, 7'h16, 1'b1, DEST_REG, 3'h0, 8'h00);
      chk("wr valid", 32'h0, wr.valid);
      chk("status", 32'h1E, st);
      u_model.mem[8'h03] = 8'hFF;
      for (int b = 0; b < 8; b++) begin
         do_op(MABA_OP_BIT_CLEAR_REG, 7'h03, 1'b0, DEST_REG, b[2:0], 8'h00);
         chk("clear data", {24'h000000, 8'hFF << (b + 1)}, wr.data);
         chk("status", 32'h1E, st);
      end
      apb_xfer(1'b1, ADDR_IRQ_MASK, 32'h0);
      pulse(1);
      chk("status", 32'h16, st);
      pulse(2);
      chk("status", 32'h06, st);
      chk("irq masked", 32'h0, irq);
      pulse(0);
      chk("status", 32'h1E, st);
      @(posedge clock_in);
      ce <= 1'b0;
      pulse(2);
      chk("status frozen", 32'h1E, st);
      @(posedge clock_in);
      ce <= 1'b1;
      apb_xfer(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk("irq status", 32'h4, rdata);
      apb_xfer(1'b0, 8'h14, 32'h0);
      chk("unmapped err", 32'h1, rerr);
      chk("unmapped data", 32'h0, rdata);
      apb_xfer(1'b1, ADDR_CONTROL, 32'h0);
      do_op(MABA_OP_ADD_IMM_ACC, 7'h00, 1'b0, DEST_ACC, 3'h0, 8'h01);
      chk("acc disabled", 32'h00, acc);
      apb_xfer(1'b1, ADDR_CONTROL, 32'h1);
      @(posedge clock_in);
      reset_n <= 1'b0;
      repeat (2) @(posedge clock_in);
      reset_n <= 1'b1;
      #1;
      chk("status", 32'h18, st);
      end_sim();
   end
endmodule // mcu_add_and_bitclear_alu_test
`default_nettype wire
